// file: shared/sbi_pkg.sv
/*
  Constants, register map and state type of the serial bus block.
  Assumes one 10 MHz clock that also stands for the high-frequency clock.
*/
`default_nettype none
package sbi_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SRST_TIME_NS = 200;
  localparam int unsigned SRST_CYCLES =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCL_N_BASE = 4; // n for rate code 000
  localparam int unsigned SCL_FIXED_HALF = 4; // half of the 8/fc term
  localparam logic [2:0] SCK_MAX_CODE = 3'h6;
  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_CTRL_A = 12'hf90; // reads status A
  localparam logic [11:0] IDX_BUF = 12'hf91;
  localparam logic [11:0] IDX_OWN = 12'hf92;
  localparam logic [11:0] IDX_CTRL_B = 12'hf93; // reads status B
  localparam logic [11:0] IDX_INT_ST = 12'hf94;
  localparam logic [11:0] IDX_INT_MASK = 12'hf95;
  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int unsigned BC_LSB = 5;
  localparam int unsigned ACK_BIT = 4;
  localparam int unsigned ALS_BIT = 0;
  localparam int unsigned MST_BIT = 7;
  localparam int unsigned TRX_BIT = 6;
  localparam int unsigned BB_BIT = 5;
  localparam int unsigned PIN_BIT = 4;
  localparam int unsigned MODE_LSB = 2;
  localparam int unsigned INT_DONE = 0;
  localparam int unsigned INT_MATCH = 1;
  localparam int unsigned INT_SRST = 2;
  localparam logic [1:0] RST_CODE_FIRST = 2'h2;
  localparam logic [1:0] RST_CODE_SECOND = 2'h1;
  localparam logic [1:0] MODE_I2C = 2'h2;
  localparam logic [3:0] FULL_BITS = 4'h8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;
  // Master engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START = 3'h1, ST_LOW = 3'h3, ST_HIGH = 3'h2,
    ST_WAIT = 3'h6, ST_STOP = 3'h7, ST_STOPH = 3'h5
  } sbi_state_t;
endpackage
`default_nettype wire

// file: shared/sbi_tick_if.sv
/*
  Rate code, run and half-period tick between engine and divider.
  Assumes both ends sit on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sbi_tick_if;
  logic [2:0] rate;
  logic run;
  logic tick;
  modport ctl (output rate, output run, input tick);
  modport div (input rate, input run, output tick);
endinterface
`default_nettype wire

// file: hdl/sbi_sync3.sv
/*
  Three-stage input synchroniser; output follows once stages two and
  three agree. Assumes an idle-high open-drain line.
*/
`timescale 1ns/1ps
`default_nettype none
module sbi_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;
  // Shift chain and agreement filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      q <= 1'b1;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule // sbi_sync3
`default_nettype wire

// file: hdl/sbi_scl_div.sv
/*
  SCL half-period divider on the core clock.
  Assumes rate code and run come from the engine on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sbi_scl_div (
  input wire logic pclk,
  input wire logic presetn,
  sbi_tick_if.div t
);
  logic [10:0] cnt;
  logic [2:0] rate_q;
  logic [2:0] code;
  logic [10:0] half;
  // Half period is 2^n + 4 cycles, n = code + 4; 111 treated as 110
  always_comb begin
    code = (t.rate > sbi_pkg::SCK_MAX_CODE) ? sbi_pkg::SCK_MAX_CODE
                                           : t.rate;
    half = 11'(11'h1 << (4'(code) + 4'(sbi_pkg::SCL_N_BASE)))
         + 11'(sbi_pkg::SCL_FIXED_HALF);
  end
  // Counter restarts whenever the code changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 11'h000;
      rate_q <= 3'h0;
      t.tick <= 1'b0;
    end else begin
      rate_q <= t.rate;
      if (!t.run || rate_q != t.rate) begin
        cnt <= 11'h000;
        t.tick <= 1'b0;
      end else if (cnt == half - 11'h001) begin
        cnt <= 11'h000;
        t.tick <= 1'b1;
      end else begin
        cnt <= cnt + 11'h001;
        t.tick <= 1'b0;
      end
    end
  end
  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    t.tick |=> (!t.tick) [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("scl tick spacing too short");
  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (t.run && rate_q != t.rate) |=> (cnt == 11'h000 && !t.tick);
  endproperty
  a_reload: assert property (p_reload)
    else $error("divider not restarted on new rate");
endmodule // sbi_scl_div
`default_nettype wire

// file: hdl/sbi_core.sv
/*
  Serial bus control block: APB registers, soft reset, master engine,
  slave receiver with own-address match, interrupt status and mask.
  Assumes open-drain SCL and SDA resolved outside, APB on pclk.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sbi_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a;
  logic [7:0] own_addr;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic mst, trx, pin, bus_busy, aas, ad0, lrb;
  logic [1:0] mode;
  logic rst_arm;
  logic [1:0] srst_cnt;
  logic srst_act, srst_go, mon;
  logic [2:0] int_st, int_mask;
  logic [11:0] idx;
  logic hit, acc, wr, wr_a, wr_b, wr_buf, wr_own, rd_buf;
  logic [7:0] rd_data;
  logic scl_s, sda_s, scl_q, sda_q;
  logic start_det, stop_det, scl_rise, scl_fall;
  sbi_pkg::sbi_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt, nbits, total_clk;
  logic m_sda_low, start_cmd, stop_cmd, m_done, bit_val;
  logic [7:0] next_shift;
  logic [7:0] sshift, next_sshift;
  logic [3:0] scnt, s_nbits, s_total;
  logic addr_phase, s_ack_low, s_byte_end, s_addr_hit, s_rx_done;
  logic s_want_ack;
  sbi_tick_if tk ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Word index, hit for the six mapped words
  assign idx = paddr[13:2];
  assign hit = paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0 &&
               idx >= sbi_pkg::IDX_CTRL_A && idx <= sbi_pkg::IDX_INT_MASK;
  assign acc = psel && penable;
  assign wr = acc && pwrite && hit;
  assign wr_a = wr && idx == sbi_pkg::IDX_CTRL_A;
  assign wr_b = wr && idx == sbi_pkg::IDX_CTRL_B;
  assign wr_buf = wr && idx == sbi_pkg::IDX_BUF;
  assign wr_own = wr && idx == sbi_pkg::IDX_OWN;
  assign rd_buf = acc && !pwrite && hit && idx == sbi_pkg::IDX_BUF;
  assign pready = 1'b1;
  assign pslverr = acc && !hit; // Unmapped word

  // Read mux; write-only words read as zero
  always_comb begin
    unique case (idx)
      sbi_pkg::IDX_CTRL_A: rd_data = {7'h00, mon};
      sbi_pkg::IDX_BUF: rd_data = rx_byte;
      sbi_pkg::IDX_CTRL_B:
        rd_data = {mst, trx, bus_busy, pin, 1'b0, aas, ad0, lrb};
      sbi_pkg::IDX_INT_ST: rd_data = {5'h00, int_st};
      sbi_pkg::IDX_INT_MASK: rd_data = {5'h00, int_mask};
      default: rd_data = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------
  assign srst_go = wr_b && mode == sbi_pkg::MODE_I2C && rst_arm &&
                   pwdata[1:0] == sbi_pkg::RST_CODE_SECOND;
  assign srst_act = srst_cnt != 2'h0;
  assign mon = !srst_act;

  // Code sequence and hold counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_arm <= 1'b0;
      srst_cnt <= 2'h0;
    end else begin
      if (srst_go) begin
        srst_cnt <= 2'(sbi_pkg::SRST_CYCLES);
      end else if (srst_act) begin
        srst_cnt <= srst_cnt - 2'h1;
      end
      if (wr_b) begin
        rst_arm <= pwdata[1:0] == sbi_pkg::RST_CODE_FIRST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control A; a start condition clears the bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a <= sbi_pkg::CTRL_A_RST;
    end else if (srst_act) begin
      ctrl_a <= sbi_pkg::CTRL_A_RST;
    end else begin
      if (wr_a) begin
        ctrl_a <= pwdata[7:0];
      end
      if (start_det) begin
        ctrl_a[7:5] <= 3'h0;
      end
    end
  end

  // Own address and transmit byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr <= sbi_pkg::OWN_ADDR_RST;
      tx_byte <= sbi_pkg::BUF_RST;
    end else if (srst_act) begin
      own_addr <= sbi_pkg::OWN_ADDR_RST;
    end else begin
      if (wr_own) begin
        own_addr <= pwdata[7:0];
      end
      if (wr_buf) begin
        tx_byte <= pwdata[7:0];
      end
    end
  end

  // Control B; operating mode survives a soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst <= 1'b0;
      trx <= 1'b0;
      mode <= 2'h0;
    end else if (srst_act) begin
      mst <= 1'b0;
      trx <= 1'b0;
    end else if (wr_b) begin
      mst <= pwdata[sbi_pkg::MST_BIT];
      trx <= pwdata[sbi_pkg::TRX_BIT];
      mode <= pwdata[sbi_pkg::MODE_LSB +: 2];
    end
  end

  // Service request: low after a byte, released by software access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b1;
    end else if (srst_act) begin
      pin <= 1'b1;
    end else if (m_done || s_rx_done || s_addr_hit) begin
      pin <= 1'b0;
    end else if (wr_buf || rd_buf ||
                 (wr_b && pwdata[sbi_pkg::PIN_BIT])) begin
      pin <= 1'b1;
    end
  end

  // Receive byte from either engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte <= sbi_pkg::BUF_RST;
    end else if (m_done) begin
      rx_byte <= next_shift;
    end else if (s_rx_done) begin
      rx_byte <= next_sshift;
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st <= sbi_pkg::INT_RST;
      int_mask <= sbi_pkg::INT_RST;
    end else begin
      int_st <= (int_st & ~((wr && idx == sbi_pkg::IDX_INT_ST) ?
                 pwdata[2:0] : 3'h0)) |
                {srst_cnt == 2'h1, s_addr_hit, m_done | s_rx_done};
      if (wr && idx == sbi_pkg::IDX_INT_MASK) begin
        int_mask <= pwdata[2:0];
      end
    end
  end
  assign irq = |(int_st & int_mask);

  // ----------------------------------------------------------------
  // Line sensing
  // ----------------------------------------------------------------
  sbi_sync3 u_scl_sync (.pclk(pclk), .presetn(presetn), .d(scl_in),
                        .q(scl_s));
  sbi_sync3 u_sda_sync (.pclk(pclk), .presetn(presetn), .d(sda_in),
                        .q(sda_s));

  // Previous line levels and bus busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (srst_act || stop_det) begin
        bus_busy <= 1'b0;
      end else if (start_det) begin
        bus_busy <= 1'b1;
      end
    end
  end
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // ----------------------------------------------------------------
  // Master engine
  // ----------------------------------------------------------------
  assign nbits = (ctrl_a[7:5] == 3'h0) ? sbi_pkg::FULL_BITS
                                       : {1'b0, ctrl_a[7:5]};
  assign total_clk = nbits + {3'h0, ctrl_a[sbi_pkg::ACK_BIT]};
  assign start_cmd = wr_b && state == sbi_pkg::ST_IDLE && !bus_busy &&
                     mode == sbi_pkg::MODE_I2C && &pwdata[7:4];
  assign stop_cmd = wr_b && state == sbi_pkg::ST_WAIT &&
                    pwdata[sbi_pkg::MST_BIT] && pwdata[sbi_pkg::TRX_BIT] &&
                    !pwdata[sbi_pkg::BB_BIT] && pwdata[sbi_pkg::PIN_BIT];
  assign m_done = state == sbi_pkg::ST_HIGH && tk.tick &&
                  bit_cnt == total_clk - 4'h1;
  assign next_shift = (bit_cnt < nbits) ? {shift[6:0], sda_s} : shift;
  // Data bit MSB first; master receiver acknowledges in the slot
  assign bit_val = (bit_cnt < nbits) ? (trx && !shift[7])
                                     : (!trx && ctrl_a[sbi_pkg::ACK_BIT]);
  assign tk.rate = ctrl_a[2:0];
  assign tk.run = state != sbi_pkg::ST_IDLE && state != sbi_pkg::ST_WAIT;

  sbi_scl_div u_div (.pclk(pclk), .presetn(presetn), .t(tk));

  // Start, bit clocks, wait with SCL low, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sbi_pkg::ST_IDLE;
      scl_oe_n <= 1'b1;
      m_sda_low <= 1'b0;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      lrb <= 1'b0;
    end else if (srst_act) begin
      state <= sbi_pkg::ST_IDLE;
      scl_oe_n <= 1'b1;
      m_sda_low <= 1'b0;
      lrb <= 1'b0;
    end else begin
      unique case (state)
        sbi_pkg::ST_IDLE: if (start_cmd) begin
          m_sda_low <= 1'b1;
          state <= sbi_pkg::ST_START;
        end
        sbi_pkg::ST_START: if (tk.tick) begin
          scl_oe_n <= 1'b0;
          shift <= tx_byte;
          bit_cnt <= 4'h0;
          state <= sbi_pkg::ST_LOW;
        end
        sbi_pkg::ST_LOW: begin
          m_sda_low <= bit_val;
          if (tk.tick) begin
            scl_oe_n <= 1'b1;
            state <= sbi_pkg::ST_HIGH;
          end
        end
        sbi_pkg::ST_HIGH: if (tk.tick) begin
          scl_oe_n <= 1'b0;
          shift <= next_shift;
          lrb <= sda_s;
          bit_cnt <= bit_cnt + 4'h1;
          state <= m_done ? sbi_pkg::ST_WAIT : sbi_pkg::ST_LOW;
        end
        sbi_pkg::ST_WAIT: begin
          m_sda_low <= 1'b0;
          if (stop_cmd) begin
            m_sda_low <= 1'b1;
            state <= sbi_pkg::ST_STOP;
          end else if (wr_buf) begin
            shift <= pwdata[7:0];
            bit_cnt <= 4'h0;
            state <= sbi_pkg::ST_LOW;
          end
        end
        sbi_pkg::ST_STOP: if (tk.tick) begin
          scl_oe_n <= 1'b1;
          state <= sbi_pkg::ST_STOPH;
        end
        sbi_pkg::ST_STOPH: if (tk.tick) begin
          m_sda_low <= 1'b0;
          state <= sbi_pkg::ST_IDLE;
        end
        default: state <= sbi_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave receiver
  // ----------------------------------------------------------------
  assign s_nbits = addr_phase ? sbi_pkg::FULL_BITS : nbits;
  assign s_total = s_nbits + {3'h0, ctrl_a[sbi_pkg::ACK_BIT]};
  assign next_sshift = {sshift[6:0], sda_s};
  assign s_byte_end = !mst && scl_rise && scnt == s_nbits - 4'h1;
  assign s_addr_hit = s_byte_end && addr_phase &&
                      ((!own_addr[sbi_pkg::ALS_BIT] &&
                        next_sshift[7:1] == own_addr[7:1]) ||
                       next_sshift == 8'h00);
  assign s_rx_done = s_byte_end && !addr_phase && aas;
  assign s_want_ack = ctrl_a[sbi_pkg::ACK_BIT] && aas && !trx;

  // Clock counting, address match, acknowledge drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt <= 4'h0;
      sshift <= 8'h00;
      addr_phase <= 1'b0;
      aas <= 1'b0;
      ad0 <= 1'b0;
      s_ack_low <= 1'b0;
    end else if (srst_act || mst) begin
      scnt <= 4'h0;
      addr_phase <= 1'b0;
      aas <= srst_act ? 1'b0 : aas;
      ad0 <= srst_act ? 1'b0 : ad0;
      s_ack_low <= 1'b0;
    end else if (start_det) begin
      scnt <= 4'h0;
      addr_phase <= 1'b1;
      aas <= 1'b0;
      ad0 <= 1'b0;
      s_ack_low <= 1'b0;
    end else begin
      if (scl_rise && scnt < s_total) begin
        scnt <= scnt + 4'h1;
        if (scnt < s_nbits) begin
          sshift <= next_sshift;
        end
      end
      if (s_byte_end && addr_phase) begin
        aas <= s_addr_hit;
        ad0 <= s_addr_hit && next_sshift == 8'h00;
      end
      if (scl_fall && scnt == s_nbits && s_want_ack) begin
        s_ack_low <= 1'b1;
      end
      if (scl_fall && scnt == s_total) begin
        scnt <= 4'h0;
        addr_phase <= 1'b0;
        s_ack_low <= 1'b0;
      end
    end
  end

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe_n = !(m_sda_low || s_ack_low);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mon;
    srst_go |=> (!mon) [*2] ##1 mon;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor did not track soft reset");
  property p_srst_clear;
    srst_go |-> ##2 (ctrl_a == sbi_pkg::CTRL_A_RST &&
                     own_addr == sbi_pkg::OWN_ADDR_RST && !mst && pin);
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset left registers set");
  property p_bc_start;
    (start_det && !srst_act) |=> ctrl_a[7:5] == 3'h0;
  endproperty
  a_bc_start: assert property (p_bc_start)
    else $error("bit count not cleared by start");
  property p_clk_count;
    (state == sbi_pkg::ST_HIGH && tk.tick && !srst_act) |=>
      (state == sbi_pkg::ST_WAIT) ==
      (bit_cnt == nbits + {3'h0, ctrl_a[sbi_pkg::ACK_BIT]});
  endproperty
  a_clk_count: assert property (p_clk_count)
    else $error("wrong clock count per transfer");
  property p_msb;
    (state == sbi_pkg::ST_HIGH && trx && bit_cnt < nbits)
      |-> m_sda_low == !shift[7];
  endproperty
  a_msb: assert property (p_msb)
    else $error("bit on SDA is not the msb");
  property p_rx_sep;
    (wr_buf && !m_done && !s_rx_done) |=> $stable(rx_byte);
  endproperty
  a_rx_sep: assert property (p_rx_sep)
    else $error("write reached the receive byte");
  property p_als;
    (s_byte_end && addr_phase && own_addr[0] && next_sshift != 8'h00)
      |=> !aas;
  endproperty
  a_als: assert property (p_als)
    else $error("address matched with recognition off");
  property p_bits8;
    (ctrl_a[7:5] == 3'h0) |-> nbits == 4'h8;
  endproperty
  a_bits8: assert property (p_bits8)
    else $error("code 000 not eight bits");
endmodule // sbi_core
`default_nettype wire

// file: verification/sbi_slave_model.sv
/*
  I2C slave model: counts SCL rises since start, keeps first byte,
  acknowledges the ninth clock; can also act as a master sending one
  address byte. Assumes pulled-up lines in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module sbi_slave_model (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  output logic scl_oe_n,
  output logic [7:0] first_byte,
  output int rises
);
  logic [7:0] shreg = 8'h00;
  initial sda_oe_n = 1'b1;
  initial scl_oe_n = 1'b1;
  initial first_byte = 8'h00;
  initial rises = 0;
  // Start condition restarts the count
  always @(negedge sda) if (scl) rises = 0;
  // Sample on rising SCL, first bit is the top bit
  always @(posedge scl) begin
    shreg = {shreg[6:0], sda};
    rises = rises + 1;
    if (rises == 8) first_byte = shreg;
  end
  // Pull SDA low through the acknowledge clock
  always @(negedge scl) sda_oe_n = (rises != 8);
  // Master role: start, address byte, acknowledge clock, stop.
  // Edges fall midway between core clock edges.
  task automatic send_addr(input logic [7:0] b, output logic ack);
    #25 sda_oe_n = 1'b0;
    #1000 scl_oe_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #500 sda_oe_n = b[i];
      #500 scl_oe_n = 1'b1;
      #1000 scl_oe_n = 1'b0;
    end
    #500 sda_oe_n = 1'b1;
    #500 scl_oe_n = 1'b1;
    #500 ack = sda;
    #500 scl_oe_n = 1'b0;
    #500 sda_oe_n = 1'b0;
    #500 scl_oe_n = 1'b1;
    #500 sda_oe_n = 1'b1;
  endtask
endmodule // sbi_slave_model
`default_nettype wire

// file: verification/tb.sv
/*
  Bench for sbi_core: APB master, slave model, pull-ups.
  Assumes zero-wait APB and open-drain lines resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, scl_oe_n, sda_oe_n, s_oe_n;
  logic irq, err, ack, m_scl_oe_n;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] got, tx, own;
  logic [2:0] bc;
  int error_cnt = 0, total_checks = 0, seed = 32'ha32af4b8, rises, r0;
  realtime t_last = 0, t_per = 0;
  wire scl = scl_oe_n & m_scl_oe_n;
  wire sda = sda_oe_n & s_oe_n;
  always #50 pclk = ~pclk;
  sbi_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
    .sda_oe_n(sda_oe_n), .irq(irq));
  sbi_slave_model i_slave (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n),
    .scl_oe_n(m_scl_oe_n), .first_byte(got), .rises(rises));
  // SCL period between the last two rises
  always @(posedge scl) begin
    t_per = $realtime - t_last;
    t_last = $realtime;
  end
  function automatic logic [31:0] n_clk(input logic [2:0] b, input logic a);
    return {28'h0, (b == 3'h0) ? 4'h8 : {1'b0, b}} + {31'h0, a};
  endfunction
  // SCL period in core cycles: 2^(n+1) + 8 with n = code + 4
  function automatic logic [31:0] scl_per(input logic [2:0] c);
    return (32'h1 << (32'(c) + 32'd5)) + 32'h8;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic wait_irq;
    repeat (3000) if (irq !== 1'b1) @(posedge pclk);
    chk("irq_wait", {31'h0, irq}, 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    #2000000;
    error_cnt++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sbi_pkg::IDX_CTRL_A, 32'h0);
    chk("monitor", rd & 32'h1, 32'h1);
    apb(1'b1, sbi_pkg::IDX_INT_MASK, 32'h7);
    apb(1'b1, sbi_pkg::IDX_OWN, 32'h1);
    tx = 8'($random(seed));
    bc = 3'($random(seed));
    apb(1'b1, sbi_pkg::IDX_BUF, {24'h0, tx});
    apb(1'b0, sbi_pkg::IDX_BUF, 32'h0);
    chk("rx_buf", rd, {24'h0, sbi_pkg::BUF_RST});
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    $display("registers test ended");
    apb(1'b1, sbi_pkg::IDX_CTRL_A, {24'h0, bc, 5'h12});
    apb(1'b1, sbi_pkg::IDX_CTRL_B, 32'h08);
    apb(1'b1, sbi_pkg::IDX_CTRL_B, 32'hf8);
    wait_irq;
    chk("clocks_addr", 32'(rises), n_clk(3'h0, 1'b1));
    chk("byte", {24'h0, got}, {24'h0, tx});
    chk("period", 32'(int'(t_per / 100.0)), scl_per(3'h2));
    apb(1'b1, sbi_pkg::IDX_CTRL_A, {24'h0, bc, 5'h02});
    apb(1'b1, sbi_pkg::IDX_INT_ST, 32'h1);
    irq_is(1'b0);
    r0 = rises;
    apb(1'b1, sbi_pkg::IDX_BUF, 32'($random(seed)) & 32'hff);
    wait_irq;
    chk("clocks_data", 32'(rises - r0), n_clk(bc, 1'b0));
    apb(1'b1, sbi_pkg::IDX_CTRL_B, 32'hd8);
    repeat (200) @(posedge pclk);
    $display("transfer test ended");
    apb(1'b1, sbi_pkg::IDX_CTRL_B, 32'h0a);
    apb(1'b1, sbi_pkg::IDX_CTRL_B, 32'h09);
    apb(1'b0, sbi_pkg::IDX_CTRL_A, 32'h0);
    chk("monitor_busy", rd & 32'h1, 32'h0);
    apb(1'b0, sbi_pkg::IDX_CTRL_A, 32'h0);
    chk("monitor_end", rd & 32'h1, 32'h1);
    apb(1'b0, sbi_pkg::IDX_INT_ST, 32'h0);
    chk("srst_done", rd & 32'h4, 32'h4);
    apb(1'b0, sbi_pkg::IDX_CTRL_B, 32'h0);
    chk("status_b", rd & 32'hf0, 32'h10);
    apb(1'b1, sbi_pkg::IDX_INT_MASK, 32'h4);
    irq_is(1'b1);
    apb(1'b1, sbi_pkg::IDX_INT_MASK, 32'h0);
    irq_is(1'b0);
    $display("soft reset test ended");
    apb(1'b1, sbi_pkg::IDX_CTRL_A, 32'h12);
    own = (8'($random(seed)) & 8'hfe) | 8'h02;
    apb(1'b1, sbi_pkg::IDX_OWN, {24'h0, own});
    apb(1'b1, sbi_pkg::IDX_INT_ST, 32'h7);
    apb(1'b1, sbi_pkg::IDX_INT_MASK, 32'h2);
    i_slave.send_addr(own, ack);
    chk("slave_ack", {31'h0, ack}, 32'h0);
    irq_is(1'b1);
    apb(1'b0, sbi_pkg::IDX_CTRL_B, 32'h0);
    chk("aas", rd & 32'h4, 32'h4);
    apb(1'b1, sbi_pkg::IDX_OWN, {24'h0, own | 8'h01});
    apb(1'b1, sbi_pkg::IDX_INT_ST, 32'h7);
    i_slave.send_addr(own, ack);
    chk("slave_nack", {31'h0, ack}, 32'h1);
    irq_is(1'b0);
    $display("slave test ended");
    test_done;
  end
endmodule // tb
`default_nettype wire
